//--- rtl/rmhw_params.svh
// Purpose: Constants for the host wake and serial handshake block
// Assumes: 125 MHz system clock
// Notes: Times are kept in their own unit; cycle counts derive from them
`ifndef RMHW_PARAMS_SVH
`define RMHW_PARAMS_SVH
`define RMHW_CLK_HZ 125000000
`define RMHW_CLK_NS 8
`define RMHW_MS_NS 1000000
`define RMHW_CYC_PER_MS ((`RMHW_MS_NS + `RMHW_CLK_NS - 1) / `RMHW_CLK_NS)
`define RMHW_POWERUP_MS 110
`define RMHW_WAKE_LEAD_MS 3
`define RMHW_BAUD_DEF 115200
`define RMHW_BAUD_MIN 9600
`define RMHW_BAUD_MAX 500000
`define RMHW_BURST_MAX 12'hC00
`define RMHW_PFX0 8'h54
`define RMHW_PFX1 8'h54
`define RMHW_PFX2 8'h4D
`define RMHW_PFX3 8'h3A
`define RMHW_TERM 24'h0D0A00
`define RMHW_OK_LEN 4'h9
`endif

//--- rtl/rmhw_pkg.sv
// Purpose: Types shared by the host wake and serial handshake block
// Assumes: Nothing beyond the params header
// Notes: Receiver state codes follow a Gray path; the sender's step from TX_SEND back to TX_IDLE changes both bits
package rmhw_pkg;
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11, RX_STOP = 2'b10} rmhw_rx_t;
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_NOTIFY = 2'b01, TX_SEND = 2'b11} rmhw_tx_t;
endpackage

//--- rtl/rmhw_strm_if.sv
// Purpose: Byte stream with valid and ready
// Assumes: Single clock
// Notes: A byte moves when valid and ready are both high
`timescale 1ns/1ns
interface rmhw_strm_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

//--- rtl/rmhw_fifo2.sv
// Purpose: Two-entry buffer between the host-bound byte sources and the serial sender
// Assumes: Sender may stall for whole milliseconds
// Notes: Ready toward the source is low only when both entries hold data
`timescale 1ns/1ns
module rmhw_fifo2 (
   input wire logic clk_sys,
   input wire logic rst_b,
   rmhw_strm_if.snk in_s,
   rmhw_strm_if.src out_s
);
   logic [7:0] mem_reg [0:1];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   logic push;
   logic pop;

   // Handshake terms
   assign in_s.ready = (count_reg != 2'h2);
   assign out_s.valid = (count_reg != 2'h0);
   assign out_s.data = mem_reg[rd_ptr_reg];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;

   // Storage and pointers
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
         mem_reg[0] <= 8'h00;
         mem_reg[1] <= 8'h00;
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_s.data;
            wr_ptr_reg <= !wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= !rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   chk_fifo_bound: assert property (@(posedge clk_sys) disable iff (!rst_b) count_reg <= 2'h2)
      else $error("buffer count beyond two");
   chk_fifo_hold_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
      out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data))
      else $error("stalled word changed");
endmodule // rmhw_fifo2

//--- rtl/rmhw_top.sv
// Purpose: Wake, radio-enable, notify and serial handshake of a wireless data module
// Assumes: Pins are asynchronous; radio-side strobes share clk_sys
// Notes: Delays in milliseconds come from a one-cycle millisecond enable
// Behaviour
// - Both control lines high: stay asleep
// - Radio-enable low: radio on, advertising
// - Radio-enable high: radio off, connection dropped
// - Keep-awake high: sleep between radio events
// - Keep-awake low: stay awake, take serial input
// - Central data reaches serial output always
// - Keep-awake high: sleep once nothing pending
// - Notify low, wait N ms, then send
// - Notify high once sending completes
// - Serial burst limited to 3K bytes
// - Baud between 9600 and 500000, matched
// - Default link 115200 baud, 8N1
// - Prefixed terminated string is command, else data
`timescale 1ns/1ns
`include "rmhw_params.svh"
module rmhw_top import rmhw_pkg::*; #(
   parameter int BAUD = `RMHW_BAUD_DEF,
   parameter int CYC_PER_MS = `RMHW_CYC_PER_MS
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic radio_enable_n,
   input wire logic keep_awake_n,
   input wire logic host_rxd,
   output logic host_txd,
   output logic notify_n,
   input wire logic [15:0] notify_delay_ms,
   input wire logic [15:0] adv_interval_ms,
   input wire logic link_event,
   input wire logic air_rx_valid,
   input wire logic [7:0] air_rx_data,
   output logic air_rx_ready,
   output logic air_tx_valid,
   output logic [7:0] air_tx_data,
   input wire logic air_tx_ready,
   output logic radio_on,
   output logic adv_event,
   output logic conn_abort,
   output logic sleep,
   output logic cmd_exec,
   output logic burst_overflow
);
   localparam logic [15:0] BIT_CYC = 16'(`RMHW_CLK_HZ / BAUD);
   localparam logic [16:0] MS_LAST = 17'(CYC_PER_MS - 1);
   logic [1:0] ren_sync_reg, wake_sync_reg, rxd_sync_reg;
   logic ren_low, wake_low, ms_tick_reg;
   logic [16:0] ms_cnt_reg;
   logic radio_on_reg, conn_abort_reg, adv_event_reg, sleep_reg, awake_next;
   logic [15:0] adv_cnt_reg, rx_cnt_reg, tx_cnt_reg, dly_cnt_reg;
   rmhw_rx_t rx_st_reg;
   rmhw_tx_t tx_st_reg;
   logic [2:0] rx_bit_reg, pm_cnt_reg, rep_len_reg, rep_idx_reg;
   logic [7:0] rx_sh_reg, rep_hold_reg, hold_d_reg;
   logic rx_v_reg, byte_ok, at_line_reg, cmd_mode_reg, rep_act_reg, ok_act_reg, cmd_exec_reg;
   logic [23:0] tail_reg;
   logic [11:0] burst_cnt_reg;
   logic ovf_reg, air_tx_valid_reg, hold_v_reg, air_rx_ready_reg, hold_v_next;
   logic [7:0] air_tx_data_reg;
   logic [3:0] ok_idx_reg, tx_bits_reg;
   logic [9:0] tx_sh_reg;
   logic tx_busy_reg, host_txd_reg, notify_n_reg;
   rmhw_strm_if fin ();
   rmhw_strm_if fout ();

   // Prefix byte lookup
   function automatic logic [7:0] pfx(input logic [2:0] i);
      case (i)
         3'h0: pfx = `RMHW_PFX0;
         3'h1: pfx = `RMHW_PFX1;
         3'h2: pfx = `RMHW_PFX2;
         default: pfx = `RMHW_PFX3;
      endcase
   endfunction

   // Acknowledge string, prefix then OK and terminator
   function automatic logic [7:0] ok_byte(input logic [3:0] i);
      case (i)
         4'h4: ok_byte = 8'h4F;
         4'h5: ok_byte = 8'h4B;
         4'h6: ok_byte = 8'h0D;
         4'h7: ok_byte = 8'h0A;
         4'h8: ok_byte = 8'h00;
         default: ok_byte = pfx(i[2:0]);
      endcase
   endfunction

   // Two-stage synchronisers for the pins
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ren_sync_reg <= 2'h3;
         wake_sync_reg <= 2'h3;
         rxd_sync_reg <= 2'h3;
      end else begin
         ren_sync_reg <= {ren_sync_reg[0], radio_enable_n};
         wake_sync_reg <= {wake_sync_reg[0], keep_awake_n};
         rxd_sync_reg <= {rxd_sync_reg[0], host_rxd};
      end
   end
   assign ren_low = !ren_sync_reg[1];
   assign wake_low = !wake_sync_reg[1];

   // Millisecond enable
   always_ff @(posedge clk_sys) begin
      if (!rst_b || ms_cnt_reg == MS_LAST) begin
         ms_cnt_reg <= 17'h00000;
         ms_tick_reg <= rst_b;
      end else begin
         ms_cnt_reg <= ms_cnt_reg + 17'h00001;
         ms_tick_reg <= 1'b0;
      end
   end

   // Radio control and advertising timer
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         radio_on_reg <= 1'b0;
         conn_abort_reg <= 1'b0;
         adv_cnt_reg <= 16'h0000;
         adv_event_reg <= 1'b0;
      end else begin
         radio_on_reg <= ren_low;
         conn_abort_reg <= radio_on_reg && !ren_low;
         adv_event_reg <= 1'b0;
         if (!radio_on_reg) begin
            adv_cnt_reg <= 16'h0000;
         end else if (ms_tick_reg) begin
            if (adv_cnt_reg + 16'h0001 >= adv_interval_ms) begin
               adv_cnt_reg <= 16'h0000;
               adv_event_reg <= 1'b1;
            end else begin
               adv_cnt_reg <= adv_cnt_reg + 16'h0001;
            end
         end
      end
   end

   // Serial receiver, armed only while held awake
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rx_st_reg <= RX_IDLE;
         rx_cnt_reg <= 16'h0000;
         rx_bit_reg <= 3'h0;
         rx_sh_reg <= 8'h00;
         rx_v_reg <= 1'b0;
      end else begin
         rx_v_reg <= 1'b0;
         rx_cnt_reg <= rx_cnt_reg + 16'h0001;
         case (rx_st_reg)
            RX_IDLE: begin
               rx_cnt_reg <= 16'h0000;
               if (wake_low && !rxd_sync_reg[1]) begin
                  rx_st_reg <= RX_START;
               end
            end
            RX_START: begin
               if (rx_cnt_reg == {1'b0, BIT_CYC[15:1]}) begin
                  rx_cnt_reg <= 16'h0000;
                  rx_bit_reg <= 3'h0;
                  rx_st_reg <= rxd_sync_reg[1] ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_cnt_reg == BIT_CYC - 16'h0001) begin
                  rx_cnt_reg <= 16'h0000;
                  rx_sh_reg <= {rxd_sync_reg[1], rx_sh_reg[7:1]};
                  rx_bit_reg <= rx_bit_reg + 3'h1;
                  if (rx_bit_reg == 3'h7) begin
                     rx_st_reg <= RX_STOP;
                  end
               end
            end
            default: begin
               if (rx_cnt_reg == BIT_CYC - 16'h0001) begin
                  rx_v_reg <= rxd_sync_reg[1];
                  rx_st_reg <= RX_IDLE;
               end
            end
         endcase
      end
   end

   // Burst length limit, restarted when keep-awake is released
   assign byte_ok = rx_v_reg && (burst_cnt_reg < `RMHW_BURST_MAX) && !rep_act_reg;
   always_ff @(posedge clk_sys) begin
      if (!rst_b || !wake_low) begin
         burst_cnt_reg <= 12'h000;
         ovf_reg <= 1'b0;
      end else if (rx_v_reg) begin
         if (byte_ok) begin
            burst_cnt_reg <= burst_cnt_reg + 12'h001;
         end else begin
            ovf_reg <= 1'b1;
         end
      end
   end

   // Command parser and raw data forwarding toward the radio
   always_ff @(posedge clk_sys) begin
      if (!rst_b || !wake_low) begin
         at_line_reg <= 1'b1;
         pm_cnt_reg <= 3'h0;
         cmd_mode_reg <= 1'b0;
         tail_reg <= 24'h000000;
         rep_act_reg <= 1'b0;
         rep_len_reg <= 3'h0;
         rep_idx_reg <= 3'h0;
         rep_hold_reg <= 8'h00;
         cmd_exec_reg <= 1'b0;
      end else begin
         cmd_exec_reg <= 1'b0;
         if (rep_act_reg && (!air_tx_valid_reg || air_tx_ready)) begin
            rep_idx_reg <= rep_idx_reg + 3'h1;
            rep_act_reg <= (rep_idx_reg != rep_len_reg);
         end
         if (byte_ok && cmd_mode_reg) begin
            tail_reg <= {tail_reg[15:0], rx_sh_reg};
            if ({tail_reg[15:0], rx_sh_reg} == `RMHW_TERM) begin
               cmd_exec_reg <= 1'b1;
               cmd_mode_reg <= 1'b0;
               at_line_reg <= 1'b1;
            end
         end else if (byte_ok && at_line_reg && rx_sh_reg == pfx(pm_cnt_reg)) begin
            pm_cnt_reg <= (pm_cnt_reg == 3'h3) ? 3'h0 : pm_cnt_reg + 3'h1;
            cmd_mode_reg <= (pm_cnt_reg == 3'h3);
            tail_reg <= 24'h000000;
         end else if (byte_ok) begin
            // Withheld prefix bytes turn out to be data and are replayed
            rep_act_reg <= (pm_cnt_reg != 3'h0);
            rep_len_reg <= pm_cnt_reg;
            rep_idx_reg <= 3'h0;
            rep_hold_reg <= rx_sh_reg;
            pm_cnt_reg <= 3'h0;
            at_line_reg <= 1'b0;
         end
      end
   end

   // Radio-bound byte register; a byte that finds it full is dropped
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         air_tx_valid_reg <= 1'b0;
         air_tx_data_reg <= 8'h00;
      end else begin
         if (air_tx_valid_reg && air_tx_ready) begin
            air_tx_valid_reg <= 1'b0;
         end
         if (rep_act_reg && (!air_tx_valid_reg || air_tx_ready)) begin
            air_tx_valid_reg <= 1'b1;
            air_tx_data_reg <= (rep_idx_reg == rep_len_reg) ? rep_hold_reg : pfx(rep_idx_reg);
         end else if (byte_ok && !cmd_mode_reg && !(at_line_reg && rx_sh_reg == pfx(pm_cnt_reg))
                      && pm_cnt_reg == 3'h0 && (!air_tx_valid_reg || air_tx_ready)) begin
            air_tx_valid_reg <= 1'b1;
            air_tx_data_reg <= rx_sh_reg;
         end
      end
   end

   // Host-bound sources: command answer first, then central data
   assign hold_v_next = (air_rx_valid && air_rx_ready_reg) ? 1'b1 :
                        (hold_v_reg && !ok_act_reg && fin.ready) ? 1'b0 : hold_v_reg;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         hold_v_reg <= 1'b0;
         hold_d_reg <= 8'h00;
         air_rx_ready_reg <= 1'b0;
         ok_act_reg <= 1'b0;
         ok_idx_reg <= 4'h0;
      end else begin
         hold_v_reg <= hold_v_next;
         air_rx_ready_reg <= !hold_v_next;
         if (air_rx_valid && air_rx_ready_reg) begin
            hold_d_reg <= air_rx_data;
         end
         if (cmd_exec_reg) begin
            ok_act_reg <= 1'b1;
            ok_idx_reg <= 4'h0;
         end else if (ok_act_reg && fin.ready) begin
            ok_idx_reg <= ok_idx_reg + 4'h1;
            ok_act_reg <= (ok_idx_reg != `RMHW_OK_LEN - 4'h1);
         end
      end
   end
   assign fin.valid = ok_act_reg || hold_v_reg;
   assign fin.data = ok_act_reg ? ok_byte(ok_idx_reg) : hold_d_reg;

   rmhw_fifo2 u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_s(fin),
      .out_s(fout)
   );

   // Notify sequencing and serial sender
   assign fout.ready = (tx_st_reg == TX_SEND) && !tx_busy_reg;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         tx_st_reg <= TX_IDLE;
         notify_n_reg <= 1'b1;
         dly_cnt_reg <= 16'h0000;
         tx_busy_reg <= 1'b0;
         tx_sh_reg <= 10'h3FF;
         tx_bits_reg <= 4'h0;
         tx_cnt_reg <= 16'h0000;
         host_txd_reg <= 1'b1;
      end else begin
         case (tx_st_reg)
            TX_IDLE: begin
               dly_cnt_reg <= 16'h0000;
               if (fout.valid) begin
                  notify_n_reg <= 1'b0;
                  tx_st_reg <= TX_NOTIFY;
               end
            end
            TX_NOTIFY: begin
               // Leave on the tick after N whole ticks, so the lead is never short of N ms
               if (notify_delay_ms == 16'h0000 || (dly_cnt_reg == notify_delay_ms && ms_tick_reg)) begin
                  tx_st_reg <= TX_SEND;
               end else if (ms_tick_reg) begin
                  dly_cnt_reg <= dly_cnt_reg + 16'h0001;
               end
            end
            default: begin
               if (!tx_busy_reg && !fout.valid) begin
                  notify_n_reg <= 1'b1;
                  tx_st_reg <= TX_IDLE;
               end
            end
         endcase
         if (fout.valid && fout.ready) begin
            tx_sh_reg <= {1'b1, fout.data, 1'b0};
            tx_bits_reg <= 4'hA;
            tx_cnt_reg <= 16'h0000;
            tx_busy_reg <= 1'b1;
            host_txd_reg <= 1'b0;
         end else if (tx_busy_reg) begin
            tx_cnt_reg <= tx_cnt_reg + 16'h0001;
            if (tx_cnt_reg == BIT_CYC - 16'h0001) begin
               tx_cnt_reg <= 16'h0000;
               tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
               tx_bits_reg <= tx_bits_reg - 4'h1;
               host_txd_reg <= (tx_bits_reg == 4'h1) ? 1'b1 : tx_sh_reg[1];
               tx_busy_reg <= (tx_bits_reg != 4'h1);
            end
         end
      end
   end

   // Sleep whenever not held awake and nothing is pending
   assign awake_next = wake_low || rx_st_reg != RX_IDLE || tx_st_reg != TX_IDLE || fout.valid || hold_v_reg
                       || ok_act_reg || rep_act_reg || air_tx_valid_reg || adv_event_reg || link_event;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sleep_reg <= 1'b1;
      end else begin
         sleep_reg <= !awake_next;
      end
   end

   assign host_txd = host_txd_reg;
   assign notify_n = notify_n_reg;
   assign air_rx_ready = air_rx_ready_reg;
   assign air_tx_valid = air_tx_valid_reg;
   assign air_tx_data = air_tx_data_reg;
   assign radio_on = radio_on_reg;
   assign adv_event = adv_event_reg;
   assign conn_abort = conn_abort_reg;
   assign sleep = sleep_reg;
   assign cmd_exec = cmd_exec_reg;
   assign burst_overflow = ovf_reg;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   chk_radio_start: assert property (ren_low |=> radio_on_reg)
      else $error("radio not on while enable low");
   chk_radio_stop: assert property ($rose(ren_sync_reg[1]) |=> !radio_on_reg && conn_abort_reg)
      else $error("radio not stopped on enable high");
   chk_sleep_quiet: assert property (!wake_low && !link_event && !radio_on_reg && rx_st_reg == RX_IDLE
      && tx_st_reg == TX_IDLE && !fout.valid && !hold_v_reg && !ok_act_reg && !rep_act_reg
      && !air_tx_valid_reg |=> sleep_reg)
      else $error("idle module not asleep");
   chk_awake_held: assert property (wake_low |=> !sleep_reg)
      else $error("slept while held awake");
   chk_rx_gate: assert property (rx_st_reg == RX_IDLE && !wake_low |=> rx_st_reg == RX_IDLE)
      else $error("receiver armed without keep-awake");
   chk_air_forward: assert property (air_rx_valid && air_rx_ready_reg |=> hold_v_reg && !air_rx_ready_reg)
      else $error("central byte not taken");
   chk_notify_lead: assert property ($fell(notify_n_reg) && notify_delay_ms != 16'h0000
      |-> host_txd_reg [*8])
      else $error("sent before notify delay");
   chk_notify_end: assert property ($rose(notify_n_reg) |-> !tx_busy_reg && !fout.valid && host_txd_reg)
      else $error("notify released mid transfer");
   chk_burst_cap: assert property (burst_cnt_reg <= `RMHW_BURST_MAX)
      else $error("burst count above limit");
   chk_baud_range: assert property (BAUD >= `RMHW_BAUD_MIN && BAUD <= `RMHW_BAUD_MAX)
      else $error("baud outside supported range");
   chk_cmd_answer: assert property (cmd_exec_reg |=> ok_act_reg ##1 fin.valid)
      else $error("command not answered");
   cov_command: cover property (cmd_exec_reg);
   cov_notify: cover property ($fell(notify_n_reg) ##[1:1000] $fell(host_txd_reg));
   cov_abort: cover property (conn_abort_reg);
   cov_overflow: cover property ($rose(ovf_reg));
endmodule // rmhw_top

//--- testbench/rmhw_host_model.sv
// Purpose: Host controller on the far side of the serial link
// Assumes: Same baud rate as the block, given in clock cycles per bit
// Notes: Idle line is high; receiver keeps every byte it frames
`timescale 1ns/1ns
module rmhw_host_model #(
   parameter int BIT_CYC = 250
) (
   input wire logic clk_sys,
   input wire logic host_txd,
   input wire logic notify_n,
   output logic host_rxd
);
   logic [7:0] rx_q[$];
   int lead_cyc = -1;
   int notify_cnt = 0;

   // Sender: 8N1, LSB first, bursts kept short
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys);
         #1 host_rxd = fr[i];
         repeat (BIT_CYC - 1) @(posedge clk_sys);
      end
   endtask

   // Idle level of the host's output line
   initial host_rxd = 1'b1;

   // Cycles the notify line has been low
   always @(posedge clk_sys) notify_cnt <= notify_n ? 0 : notify_cnt + 1;

   // Receiver: start edge, then mid-bit samples at the shared rate
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge host_txd);
         if (lead_cyc < 0) lead_cyc = notify_cnt;
         repeat (BIT_CYC / 2) @(posedge clk_sys);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_sys);
            b[i] = host_txd;
         end
         repeat (BIT_CYC) @(posedge clk_sys);
         rx_q.push_back(b);
      end
   end
endmodule // rmhw_host_model

//--- testbench/radio_module_host_wake_handshake_tb.sv
// Purpose: Self-checking bench for the wake, radio-enable, notify and serial block
// Assumes: Millisecond shortened to 20 cycles, link at 500000 baud
// Notes: The host model plays the controller on the serial side
`timescale 1ns/1ns
module radio_module_host_wake_handshake_tb;
   localparam int CPM = 20;
   localparam int BIT = 250;
   localparam int ND = 2;
   localparam int AI = 5;
   logic clk_sys, rst_b, radio_enable_n, keep_awake_n, host_rxd, host_txd, notify_n;
   logic link_event, air_rx_valid, air_rx_ready, air_tx_valid, air_tx_ready;
   logic radio_on, adv_event, conn_abort, sleep, cmd_exec, burst_overflow;
   logic [7:0] air_rx_data, air_tx_data;
   logic [7:0] air_q[$];
   logic [7:0] cen_q[$] = '{8'hA5, 8'h3C, 8'h81, 8'h0F, 8'hFF};
   int miscompares, samples_checked, cycles, cmd_cnt;

   rmhw_top #(.BAUD(500000), .CYC_PER_MS(CPM)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .radio_enable_n(radio_enable_n), .keep_awake_n(keep_awake_n), .host_rxd(host_rxd),
      .host_txd(host_txd), .notify_n(notify_n), .notify_delay_ms(16'(ND)), .adv_interval_ms(16'(AI)),
      .link_event(link_event), .air_rx_valid(air_rx_valid), .air_rx_data(air_rx_data),
      .air_rx_ready(air_rx_ready), .air_tx_valid(air_tx_valid), .air_tx_data(air_tx_data),
      .air_tx_ready(air_tx_ready), .radio_on(radio_on), .adv_event(adv_event), .conn_abort(conn_abort),
      .sleep(sleep), .cmd_exec(cmd_exec), .burst_overflow(burst_overflow));
   rmhw_host_model #(.BIT_CYC(BIT)) host (.clk_sys(clk_sys), .host_txd(host_txd), .notify_n(notify_n),
      .host_rxd(host_rxd));

   // Clock at 125 MHz
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Records bytes handed to the radio, command pulses and run length
   always @(posedge clk_sys) begin
      if (air_tx_valid === 1'b1 && air_tx_ready === 1'b1) air_q.push_back(air_tx_data);
      if (cmd_exec === 1'b1) cmd_cnt++;
      cycles++;
      if (cycles == 100000) begin
         miscompares++;
         complete_run();
      end
   end

   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic send_bytes(input logic [7:0] s[$]);
      foreach (s[i]) host.send_byte(s[i]);
   endtask

   // Waits for the host to frame the expected bytes, then compares them
   task automatic expect_rx(input logic [7:0] e[$], input int lim);
      int n;
      for (n = 0; n < lim && host.rx_q.size() < e.size(); n++) tick();
      check("rx count", 16'(host.rx_q.size()), 16'(e.size()));
      foreach (e[i]) check("rx byte", (i < host.rx_q.size()) ? host.rx_q[i] : 8'h00, e[i]);
      host.rx_q.delete();
   endtask

   task automatic test_idle();
      check("notify_n", notify_n, 1'b1);
      check("sleep", sleep, 1'b1);
      check("radio_on", radio_on, 1'b0);
      check("host_txd", host_txd, 1'b1);
      $display("test idle done");
   endtask

   task automatic test_radio();
      int n;
      radio_enable_n = 1'b0;
      repeat (4) tick();
      check("radio_on", radio_on, 1'b1);
      for (n = 0; n < AI * CPM + 8 && adv_event !== 1'b1; n++) tick();
      check("adv_event", adv_event, 1'b1);
      repeat (2) tick();
      check("sleep", sleep, 1'b1);
      for (n = 0; n < AI * CPM + 8 && adv_event !== 1'b1; n++) tick();
      check("adv period", 16'(n), 16'(AI * CPM - 2));
      repeat (2) tick();
      link_event = 1'b1;
      tick();
      link_event = 1'b0;
      check("sleep on event", sleep, 1'b0);
      tick();
      check("sleep after event", sleep, 1'b1);
      radio_enable_n = 1'b1;
      for (n = 0; n < 6 && conn_abort !== 1'b1; n++) tick();
      check("conn_abort", conn_abort, 1'b1);
      check("radio_on", radio_on, 1'b0);
      tick();
      check("conn_abort", conn_abort, 1'b0);
      for (n = 0; n < AI * CPM + 8 && adv_event !== 1'b1; n++) tick();
      check("adv after off", adv_event, 1'b0);
      $display("test radio done");
   endtask

   // Central bytes pushed faster than the link drains them, keep-awake high
   task automatic test_central();
      int n, stall;
      stall = 0;
      host.lead_cyc = -1;
      foreach (cen_q[i]) begin
         air_rx_valid = 1'b1;
         air_rx_data = cen_q[i];
         for (n = 0; n < 9000 && air_rx_ready !== 1'b1; n++) tick();
         if (n > 0) stall = 1;
         tick();
         check("air_rx_ready", air_rx_ready, 1'b0);
         air_rx_valid = 1'b0;
         tick();
      end
      check("buffer stall", 16'(stall), 16'h0001);
      check("notify_n", notify_n, 1'b0);
      expect_rx(cen_q, 20000);
      check("notify lead", 16'(host.lead_cyc >= ND * CPM && host.lead_cyc <= (ND + 1) * CPM + 8), 16'h0001);
      for (n = 0; n < BIT && notify_n !== 1'b1; n++) tick();
      check("notify_n", notify_n, 1'b1);
      $display("test central done");
   endtask

   task automatic test_host_in();
      int n;
      air_q.delete();
      keep_awake_n = 1'b0;
      repeat (3 * CPM) tick();
      check("sleep", sleep, 1'b0);
      host.send_byte(8'h41);
      for (n = 0; n < 20 && air_tx_valid !== 1'b1; n++) tick();
      repeat (10) tick();
      check("air_tx_valid", air_tx_valid, 1'b1);
      check("air_tx_data", air_tx_data, 8'h41);
      air_tx_ready = 1'b1;
      repeat (2) tick();
      check("air_tx_valid", air_tx_valid, 1'b0);
      repeat (3 * CPM) tick();
      keep_awake_n = 1'b1;
      for (n = 0; n < 20 && sleep !== 1'b1; n++) tick();
      check("sleep", sleep, 1'b1);
      host.send_byte(8'h42);
      repeat (20) tick();
      check("ignored byte", 16'(air_q.size()), 16'h0001);
      $display("test host in done");
   endtask

   task automatic test_command();
      air_q.delete();
      cmd_cnt = 0;
      keep_awake_n = 1'b0;
      radio_enable_n = 1'b0;
      repeat (3 * CPM) tick();
      check("radio_on tied", radio_on, 1'b1);
      check("sleep tied", sleep, 1'b0);
      send_bytes('{8'h54, 8'h54, 8'h4D, 8'h3A, 8'h0D, 8'h0A, 8'h00});
      expect_rx('{8'h54, 8'h54, 8'h4D, 8'h3A, 8'h4F, 8'h4B, 8'h0D, 8'h0A, 8'h00}, 30000);
      check("cmd_exec count", 16'(cmd_cnt), 16'h0001);
      check("forwarded", 16'(air_q.size()), 16'h0000);
      send_bytes('{8'h54, 8'h58});
      repeat (20) tick();
      check("replay count", 16'(air_q.size()), 16'h0002);
      check("replay first", air_q[0], 8'h54);
      check("replay second", air_q[1], 8'h58);
      check("burst_overflow", burst_overflow, 1'b0);
      radio_enable_n = 1'b1;
      repeat (3 * CPM) tick();
      keep_awake_n = 1'b1;
      $display("test command done");
   endtask

   task automatic complete_run();
      $display("checks made %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Reset, power-up wait, then the scenarios in turn
   initial begin
      rst_b = 1'b0;
      radio_enable_n = 1'b1;
      keep_awake_n = 1'b1;
      link_event = 1'b0;
      air_rx_valid = 1'b0;
      air_rx_data = 8'h00;
      air_tx_ready = 1'b0;
      repeat (16) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      test_idle();
      repeat (110 * CPM) tick();
      test_idle();
      test_radio();
      test_central();
      test_host_in();
      test_command();
      complete_run();
   end
endmodule // radio_module_host_wake_handshake_tb
